// *** core/iepf_pkg.sv ***
// Purpose: shared constants for interrupt entry, return and power-fail handling
// Assumes: one processor clock at 250 MHz, 16-bit location counter, 8-bit accumulator
// Notes: line n is masked by mask bit (NUM_LINES-1-n), so 8'h40 opens line 1
//
// Notes on behaviour
// RULE1 - accepting an interrupt clears the global enable until software sets it again
// RULE2 - entry stores interrupted location counter with old enable in bit 14
// RULE3 - indirect branch through a word with enable bit set resumes and re-enables
// RULE4 - power-fail line obeys its mask bit but ignores the global enable
// RULE5 - after power returns, execution restarts at location 0000
// RULE6 - command 03 signals power-down and halts the processor
// RULE7 - command 80 copies the carry flag onto the serial output port
// RULE8 - running clock, unmasked and enabled, requests an interrupt every millisecond
// RULE9 - command 28 starts the clock, sets enable, accumulator gives the mask
// RULE10 - mask value 40 opens only line 1, where the clock is wired
// RULE11 - serial input may be wired externally to a line, low level requests; the lines here request on a high level
// RULE12 - command 10 copies the serial input level into the carry flag
// RULE13 - service starts at the word after the stored return word
// RULE14 - entries sit at fixed addresses eight bytes apart, line 1 at 0108

package iepf_pkg;

    // ****************************************************************
    // widths and line layout
    // ****************************************************************
    localparam int NUM_LINES = 8;
    localparam int LINE_W = 3;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int EXT_LINES = NUM_LINES - 1;
    localparam logic [LINE_W-1:0] POWER_FAIL_LINE = 3'h0;
    localparam logic [LINE_W-1:0] CLOCK_LINE = 3'h1;
    localparam int FIRST_EXT_LINE = 1;

    // ****************************************************************
    // addresses
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ENTRY_BASE = 16'h0100;
    localparam logic [ADDR_W-1:0] ENTRY_STRIDE = 16'h0008;
    localparam logic [ADDR_W-1:0] SERVICE_OFFSET = 16'h0002;
    localparam logic [ADDR_W-1:0] RESTART_ADDR = 16'h0000;
    localparam int ENABLE_BIT = 14;
    localparam logic [ADDR_W-1:0] ENABLE_FLAG = 16'h4000;

    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [DATA_W-1:0] CMD_POWER_DOWN = 8'h03;
    localparam logic [DATA_W-1:0] CMD_ENABLE = 8'h08;
    localparam logic [DATA_W-1:0] CMD_SERIAL_IN = 8'h10;
    localparam logic [DATA_W-1:0] CMD_CLOCK_START = 8'h28;
    localparam logic [DATA_W-1:0] CMD_SERIAL_OUT = 8'h80;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
    localparam logic SERIAL_IDLE = 1'b1;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLOCK_PERIOD_NS;

    typedef enum logic {
        st_run,
        st_halt
    } iepf_state_e;

endpackage

// *** core/iepf_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter, one per bit
// Assumes: inputs are asynchronous levels
// Notes: output moves only when the second and third stages agree

`timescale 1ns/1ns

module iepf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // raw and filtered levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // ****************************************************************
    // per-bit filter
    // ****************************************************************
    // stage1 feeds only stage2, so no logic ever sees a metastable value
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end

endmodule

// *** core/iepf_top.sv ***
// Purpose: interrupt entry and return, power-fail, restart, clock tick and serial port
// Assumes: the core reports instruction boundaries, commands and indirect branches
// Notes: all outputs registered, so every effect of a core input shows one cycle after its cause; pin effects also wait on the synchronisers

`timescale 1ns/1ns

module iepf_top #(
    parameter int TICK_CYCLES = iepf_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // core status
    input wire logic insn_boundary,
    input wire logic [iepf_pkg::ADDR_W-1:0] location_counter,
    input wire logic carry_flag,
    input wire logic [iepf_pkg::DATA_W-1:0] accumulator,
    // command instruction
    input wire logic cmd_valid,
    input wire logic [iepf_pkg::DATA_W-1:0] cmd_code,
    // indirect branch
    input wire logic branch_ind_valid,
    input wire logic [iepf_pkg::ADDR_W-1:0] branch_word,
    // pins
    input wire logic power_fail,
    input wire logic power_ok,
    input wire logic [iepf_pkg::EXT_LINES-1:0] ext_irq,
    input wire logic serial_in,
    // interrupt state
    output logic int_enable,
    output logic [iepf_pkg::DATA_W-1:0] int_mask,
    output logic irq_taken,
    output logic [iepf_pkg::LINE_W-1:0] irq_line,
    // return word store
    output logic save_write,
    output logic [iepf_pkg::ADDR_W-1:0] save_addr,
    output logic [iepf_pkg::ADDR_W-1:0] save_data,
    // location counter load
    output logic pc_load,
    output logic [iepf_pkg::ADDR_W-1:0] pc_value,
    // carry and serial port
    output logic carry_load,
    output logic carry_value,
    output logic serial_out,
    // power and run state
    output logic power_down,
    output logic halted,
    output logic clock_running
);
    import iepf_pkg::*;

    localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [TICK_W-1:0] TICK_ZERO = '0;

    // ****************************************************************
    // synchronised pins
    // ****************************************************************
    logic pf_level;
    logic pok_level;
    logic ser_level;
    logic [EXT_LINES-1:0] ext_level;

    iepf_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_pf (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(power_fail),
        .level(pf_level)
    );

    iepf_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_pok (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(power_ok),
        .level(pok_level)
    );

    iepf_sync #(.WIDTH(1), .RESET_VAL(SERIAL_IDLE)) u_sync_ser (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(serial_in),
        .level(ser_level)
    );

    iepf_sync #(.WIDTH(EXT_LINES), .RESET_VAL('0)) u_sync_ext (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(ext_irq),
        .level(ext_level)
    );

    // ****************************************************************
    // millisecond clock
    // ****************************************************************
    logic [TICK_W-1:0] tick_count;
    logic [TICK_W-1:0] next_tick_count;
    logic tick;

    // free counting only while started; the first start begins a full period, a later command 28 leaves the count running
    always_comb begin
        next_tick_count = TICK_ZERO;
        tick = 1'b0;
        if (clock_running) begin
            if (tick_count == TICK_LAST) begin
                tick = 1'b1; // see RULE8
            end else begin
                next_tick_count = tick_count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_count <= TICK_ZERO;
        end else begin
            tick_count <= next_tick_count;
        end
    end

    // ****************************************************************
    // request vector and priority
    // ****************************************************************
    logic pf_prev;
    logic pok_prev;
    logic pf_pend;
    logic tick_pend;
    logic [NUM_LINES-1:0] line_req;
    logic [NUM_LINES-1:0] eligible;
    logic any_eligible;
    logic [LINE_W-1:0] win_line;

    assign line_req[POWER_FAIL_LINE] = pf_pend;

    genvar g;
    generate
        for (g = FIRST_EXT_LINE; g < NUM_LINES; g++) begin : g_line
            if (g == CLOCK_LINE) begin : g_clk
                assign line_req[g] = tick_pend | ext_level[g-FIRST_EXT_LINE];
            end else begin : g_ext
                // a serial line wired here by the board requests on its high level
                assign line_req[g] = ext_level[g-FIRST_EXT_LINE]; // see RULE11
            end
            // see RULE10
            assign eligible[g] = line_req[g] & int_mask[NUM_LINES-1-g] & int_enable;
        end
    endgenerate

    // power fail ignores the global enable
    assign eligible[POWER_FAIL_LINE] = pf_pend & int_mask[NUM_LINES-1]; // see RULE4

    // lowest line number wins
    always_comb begin
        win_line = POWER_FAIL_LINE;
        any_eligible = 1'b0;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                win_line = LINE_W'(i);
                any_eligible = 1'b1;
            end
        end
    end

    // ****************************************************************
    // control group
    // ****************************************************************
    iepf_state_e state;
    iepf_state_e next_state;
    logic pf_rise;
    logic restart;
    logic take;
    logic [ADDR_W-1:0] entry_addr;
    logic next_int_enable;
    logic [DATA_W-1:0] next_int_mask;
    logic next_irq_taken;
    logic [LINE_W-1:0] next_irq_line;
    logic next_save_write;
    logic [ADDR_W-1:0] next_save_addr;
    logic [ADDR_W-1:0] next_save_data;
    logic next_pc_load;
    logic [ADDR_W-1:0] next_pc_value;
    logic next_carry_load;
    logic next_carry_value;
    logic next_serial_out;
    logic next_power_down;
    logic next_clock_running;
    logic next_pf_pend;
    logic next_tick_pend;
    logic pf_clear;
    logic tick_clear;

    assign pf_rise = pf_level & ~pf_prev;
    assign restart = pok_level & ~pok_prev;
    // interrupts are taken only at a boundary with no instruction effect pending
    assign take = (state == st_run) & insn_boundary & any_eligible & ~cmd_valid &
        ~branch_ind_valid & ~restart;
    assign entry_addr = ENTRY_BASE + ADDR_W'(ADDR_W'(win_line) * ENTRY_STRIDE); // see RULE14

    always_comb begin
        next_state = state;
        next_int_enable = int_enable;
        next_int_mask = int_mask;
        next_irq_taken = 1'b0;
        next_irq_line = irq_line;
        next_save_write = 1'b0;
        next_save_addr = save_addr;
        next_save_data = save_data;
        next_pc_load = 1'b0;
        next_pc_value = pc_value;
        next_carry_load = 1'b0;
        next_carry_value = carry_value;
        next_serial_out = serial_out;
        next_power_down = power_down;
        next_clock_running = clock_running;
        pf_clear = 1'b0;
        tick_clear = 1'b0;
        if (restart) begin
            next_state = st_run;
            next_pc_load = 1'b1;
            next_pc_value = RESTART_ADDR; // see RULE5
            next_power_down = 1'b0;
            next_int_enable = 1'b0;
            pf_clear = 1'b1;
        end else if (state == st_run) begin
            if (branch_ind_valid) begin
                next_pc_load = 1'b1;
                next_pc_value = branch_word & ~ENABLE_FLAG;
                if (branch_word[ENABLE_BIT]) begin
                    next_int_enable = 1'b1; // see RULE3
                end
            end else if (cmd_valid) begin
                unique case (cmd_code)
                    CMD_POWER_DOWN: begin
                        next_power_down = 1'b1; // see RULE6
                        next_state = st_halt;
                    end
                    CMD_ENABLE: begin
                        next_int_enable = 1'b1;
                    end
                    CMD_SERIAL_IN: begin
                        next_carry_load = 1'b1;
                        next_carry_value = ser_level; // see RULE12
                    end
                    CMD_CLOCK_START: begin
                        next_clock_running = 1'b1; // see RULE9
                        next_int_enable = 1'b1;
                        next_int_mask = accumulator;
                    end
                    CMD_SERIAL_OUT: begin
                        next_serial_out = carry_flag; // see RULE7
                    end
                    default: begin
                    end
                endcase
            end else if (take) begin
                next_int_enable = 1'b0; // see RULE1
                next_irq_taken = 1'b1;
                next_irq_line = win_line;
                next_save_write = 1'b1;
                next_save_addr = entry_addr;
                // see RULE2
                next_save_data = (location_counter & ~ENABLE_FLAG) |
                    (int_enable ? ENABLE_FLAG : '0);
                next_pc_load = 1'b1;
                next_pc_value = entry_addr + SERVICE_OFFSET; // see RULE13
                pf_clear = (win_line == POWER_FAIL_LINE);
                tick_clear = (win_line == CLOCK_LINE);
            end
        end
        // a new event in the clearing cycle survives the clear
        next_pf_pend = pf_rise | (pf_pend & ~pf_clear);
        next_tick_pend = tick | (tick_pend & ~tick_clear); // see RULE8
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= st_run;
            pf_prev <= 1'b0;
            pok_prev <= 1'b1;
            pf_pend <= 1'b0;
            tick_pend <= 1'b0;
            int_enable <= 1'b0;
            int_mask <= MASK_RESET;
            irq_taken <= 1'b0;
            irq_line <= POWER_FAIL_LINE;
            save_write <= 1'b0;
            save_addr <= RESTART_ADDR;
            save_data <= RESTART_ADDR;
            pc_load <= 1'b0;
            pc_value <= RESTART_ADDR;
            carry_load <= 1'b0;
            carry_value <= 1'b0;
            serial_out <= SERIAL_IDLE;
            power_down <= 1'b0;
            halted <= 1'b0;
            clock_running <= 1'b0;
        end else begin
            state <= next_state;
            pf_prev <= pf_level;
            pok_prev <= pok_level;
            pf_pend <= next_pf_pend;
            tick_pend <= next_tick_pend;
            int_enable <= next_int_enable;
            int_mask <= next_int_mask;
            irq_taken <= next_irq_taken;
            irq_line <= next_irq_line;
            save_write <= next_save_write;
            save_addr <= next_save_addr;
            save_data <= next_save_data;
            pc_load <= next_pc_load;
            pc_value <= next_pc_value;
            carry_load <= next_carry_load;
            carry_value <= next_carry_value;
            serial_out <= next_serial_out;
            power_down <= next_power_down;
            halted <= (next_state == st_halt);
            clock_running <= next_clock_running;
        end
    end

endmodule

// *** dv/iepf_top_properties.sv ***
// Purpose: concurrent checks on the entry, return, command and restart ports
// Assumes: one clock, sync active-high reset, effects one cycle after cause
// Notes: saved word keeps only bits 14 and 13:0 meaningful

`timescale 1ns/1ns

module iepf_top_properties #(
    parameter int TICK_CYCLES = 20
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // core side
    input wire logic [iepf_pkg::ADDR_W-1:0] location_counter,
    input wire logic carry_flag,
    input wire logic [iepf_pkg::DATA_W-1:0] accumulator,
    input wire logic cmd_valid,
    input wire logic [iepf_pkg::DATA_W-1:0] cmd_code,
    input wire logic branch_ind_valid,
    input wire logic [iepf_pkg::ADDR_W-1:0] branch_word,
    // device outputs
    input wire logic int_enable,
    input wire logic [iepf_pkg::DATA_W-1:0] int_mask,
    input wire logic irq_taken,
    input wire logic [iepf_pkg::LINE_W-1:0] irq_line,
    input wire logic save_write,
    input wire logic [iepf_pkg::ADDR_W-1:0] save_addr,
    input wire logic [iepf_pkg::ADDR_W-1:0] save_data,
    input wire logic pc_load,
    input wire logic [iepf_pkg::ADDR_W-1:0] pc_value,
    input wire logic carry_load,
    input wire logic serial_out,
    input wire logic power_down,
    input wire logic halted,
    input wire logic clock_running
);
    import iepf_pkg::*;

    // ****************************************************************
    // sequences
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // branch outranks commands, so a command counts only alone
    sequence s_cmd(logic [7:0] c);
        cmd_valid && cmd_code == c && !halted && !branch_ind_valid;
    endsequence

    sequence s_entry;
        save_write && pc_load && pc_value == save_addr + SERVICE_OFFSET;
    endsequence

    // ****************************************************************
    // assertions
    // ****************************************************************
    take_clears_en_a: assert property (irq_taken |-> !int_enable)
        else $error("enable still on after entry");
    save_word_a: assert property (irq_taken |-> save_data[ENABLE_BIT] == $past(int_enable)
        && save_data[13:0] == $past(location_counter[13:0])) else $error("bad saved word");
    entry_addr_a: assert property (irq_taken |-> s_entry
        and save_addr == ENTRY_BASE + ENTRY_STRIDE * irq_line) else $error("bad entry address");
    mask_gate_a: assert property (irq_taken |-> ($past(int_mask) & (8'h80 >> irq_line)) != 8'h00)
        else $error("masked line taken");
    enable_gate_a: assert property (irq_taken && irq_line != POWER_FAIL_LINE |-> $past(int_enable))
        else $error("line taken while disabled");
    resume_on_a: assert property (branch_ind_valid && !halted && branch_word[ENABLE_BIT] |=>
        pc_load && int_enable && pc_value == ($past(branch_word) & ~ENABLE_FLAG))
        else $error("bad return branch");
    power_down_a: assert property (s_cmd(CMD_POWER_DOWN) |=> (power_down && halted) [*2])
        else $error("power down not held");
    serial_out_a: assert property (s_cmd(CMD_SERIAL_OUT) |=> serial_out == $past(carry_flag))
        else $error("serial out not carry");
    serial_in_a: assert property (s_cmd(CMD_SERIAL_IN) ##1 !cmd_valid |->
        carry_load ##1 !carry_load) else $error("carry load not a pulse");
    clock_start_a: assert property (s_cmd(CMD_CLOCK_START) |=>
        clock_running && int_enable && int_mask == $past(accumulator)) else $error("bad clock start");
    restart_a: assert property ($rose(pc_load) && pc_value == RESTART_ADDR && $past(halted)
        |-> !halted && !power_down) else $error("restart left halt");
endmodule

bind iepf_top iepf_top_properties #(.TICK_CYCLES(TICK_CYCLES)) iepf_top_properties_inst (
    .clock, .sys_rst, .location_counter, .carry_flag, .accumulator, .cmd_valid, .cmd_code,
    .branch_ind_valid, .branch_word, .int_enable, .int_mask, .irq_taken, .irq_line, .save_write,
    .save_addr, .save_data, .pc_load, .pc_value, .carry_load, .serial_out, .power_down, .halted,
    .clock_running);

// *** dv/iepf_partner.sv ***
// Purpose: peripheral request lines and terminal line facing the device
// Assumes: requests are levels held until the device accepts them
// Notes: serial level comes straight from the bench

`timescale 1ns/1ns

module iepf_partner (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // bench requests
    input wire logic [iepf_pkg::EXT_LINES-1:0] raise,
    input wire logic ser_bit,
    // device acknowledge
    input wire logic irq_taken,
    input wire logic [iepf_pkg::LINE_W-1:0] irq_line,
    // pins toward the device
    output logic [iepf_pkg::EXT_LINES-1:0] ext_irq,
    output logic serial_in
);
    import iepf_pkg::*;
    logic [EXT_LINES-1:0] drop;

    // ****************************************************************
    // request lines
    // ****************************************************************
    always_comb begin
        drop = '0;
        if (irq_taken && irq_line != POWER_FAIL_LINE) begin
            drop[irq_line - 3'h1] = 1'b1;
        end
    end

    // a device dropping its request only once served, never earlier
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_irq <= '0;
        end else begin
            ext_irq <= (ext_irq | raise) & ~drop;
        end
    end

    // terminal line idles high; a board may route its low level to a line
    assign serial_in = ser_bit;
endmodule

// *** dv/iepf_top_test.sv ***
// Purpose: directed checks of entry, return, tick, serial, power fail and restart
// Assumes: tick period shortened to TICK cycles
// Notes: inputs change 1 ns after each rising edge

`timescale 1ns/1ns

module iepf_top_test;
    import iepf_pkg::*;
    localparam int TICK = 20;
    logic clock = 0, sys_rst = 1, insn_boundary = 0, carry_flag = 0, cmd_valid = 0;
    logic branch_ind_valid = 0, power_fail = 0, power_ok = 1, ser_bit = 1;
    logic [15:0] location_counter = 16'h0234, branch_word = 16'h0000;
    logic [7:0] accumulator = 8'h00, cmd_code = 8'h00;
    logic [6:0] raise = 7'h00, ext_irq;
    logic serial_in, int_enable, irq_taken, save_write, pc_load, carry_load, carry_value;
    logic serial_out, power_down, halted, clock_running;
    logic [7:0] int_mask;
    logic [2:0] irq_line;
    logic [15:0] save_addr, save_data, pc_value;
    int error_cnt = 0, cmp_count = 0, cyc = 0, n;

    iepf_top #(.TICK_CYCLES(TICK)) iepf_top_inst (.clock, .sys_rst, .insn_boundary,
        .location_counter, .carry_flag, .accumulator, .cmd_valid, .cmd_code, .branch_ind_valid,
        .branch_word, .power_fail, .power_ok, .ext_irq, .serial_in, .int_enable, .int_mask,
        .irq_taken, .irq_line, .save_write, .save_addr, .save_data, .pc_load, .pc_value,
        .carry_load, .carry_value, .serial_out, .power_down, .halted, .clock_running);
    iepf_partner iepf_partner_inst (.clock, .sys_rst, .raise, .ser_bit, .irq_taken,
        .irq_line, .ext_irq, .serial_in);

    // ****************************************************************
    // helpers
    // ****************************************************************
    always #2 clock = ~clock;

    task close_out;
        $display("errors %0d, checks %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out;
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task step;
        @(posedge clock);
        #1;
    endtask

    // one idle edge first, so a strobe just lowered is never raised in the same step
    task cmd(input logic [7:0] c, input logic [7:0] a);
        step;
        accumulator = a;
        cmd_code = c;
        cmd_valid = 1;
        step;
        cmd_valid = 0;
    endtask

    task branch(input logic [15:0] w);
        branch_word = w;
        branch_ind_valid = 1;
        step;
        branch_ind_valid = 0;
    endtask

    task wait_take;
        n = 0;
        while (irq_taken !== 1'b1 && n < 200) begin
            step;
            n++;
        end
        chk(irq_taken, 1);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_serial;
        ser_bit = 0;
        repeat (6) step;
        carry_flag = 1;
        cmd(CMD_SERIAL_OUT, 8'h00);
        chk(serial_out, 1);
        cmd(CMD_SERIAL_IN, 8'h00);
        chk(carry_load, 1);
        chk(carry_value, 0);
        carry_flag = 0;
        cmd(CMD_SERIAL_OUT, 8'h00);
        chk(serial_out, 0);
        ser_bit = 1;
        repeat (6) step;
        cmd(CMD_SERIAL_IN, 8'h00);
        chk(carry_value, 1);
    endtask

    task t_tick;
        insn_boundary = 1;
        raise = 7'h02;
        step;
        raise = 7'h00;
        cmd(CMD_CLOCK_START, 8'h40);
        chk(clock_running, 1);
        chk(int_enable, 1);
        chk(int_mask, 16'h0040);
        wait_take;
        chk(irq_line, 1);
        chk(save_addr, 16'h0108);
        chk(save_data, 16'h4234);
        chk(pc_value, 16'h010a);
        chk(int_enable, 0);
        branch(16'h4234);
        chk(pc_load, 1);
        chk(pc_value, 16'h0234);
        chk(int_enable, 1);
        wait_take;
        chk(16'(n + 1), 16'(TICK));
        chk(irq_line, 1);
        branch(16'h0234);
        chk(int_enable, 0);
        cmd(CMD_ENABLE, 8'h00);
        chk(int_enable, 1);
        cmd(CMD_CLOCK_START, 8'h20);
        wait_take;
        chk(irq_line, 2);
        chk(save_addr, 16'h0110);
        chk(pc_value, 16'h0112);
    endtask

    task pf_take;
        power_fail = 1;
        wait_take;
        power_fail = 0;
        chk(irq_line, 0);
        chk(save_addr, 16'h0100);
        chk(pc_value, 16'h0102);
        repeat (6) step;
    endtask

    task t_power;
        cmd(CMD_CLOCK_START, 8'h80);
        pf_take;
        chk(save_data, 16'h4234);
        pf_take;
        chk(save_data, 16'h0234);
        cmd(CMD_POWER_DOWN, 8'h00);
        chk(power_down, 1);
        chk(halted, 1);
        carry_flag = 1;
        cmd(CMD_SERIAL_OUT, 8'h00);
        chk(serial_out, 0);
        power_ok = 0;
        repeat (6) step;
        power_ok = 1;
        n = 0;
        while (pc_load !== 1'b1 && n < 20) begin
            step;
            n++;
        end
        chk(pc_load, 1);
        chk(pc_value, 16'h0000);
        chk(halted, 0);
        chk(power_down, 0);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        #1 sys_rst = 0;
        chk(int_enable, 0);
        chk(int_mask, 16'h0000);
        chk(serial_out, 1);
        chk(halted, 0);
        t_serial;
        t_tick;
        t_power;
        close_out;
    end
endmodule
